/* File: shared/awh_pkg.sv */
// Purpose: constants, carriers and state type for the area wait/hold block
// Assumes: one chip-select area, apb register access, pclk at 125 MHz
// Notes:   half-cycle figures are rounded up to whole pclk cycles
package awh_pkg;

	// register map
	localparam logic [11:0] AWH_WAIT_CTRL_OFS = 12'h000;

	// field positions inside the wait control word
	localparam int AWH_RD_WAIT_LSB = 7;
	localparam int AWH_RD_WAIT_MSB = 10;
	localparam int AWH_EXT_MASK_BIT = 6;
	localparam int AWH_RSVD_LSB = 2;
	localparam int AWH_RSVD_MSB = 5;
	localparam int AWH_HOLD_LSB = 0;
	localparam int AWH_HOLD_MSB = 1;

	// reset values
	localparam logic [3:0] AWH_RD_WAIT_RST = 4'ha;
	localparam logic       AWH_EXT_MASK_RST = 1'h0;
	localparam logic [1:0] AWH_HOLD_RST = 2'h0;

	// timing: strobe delay after select is 0.5 cycle, counted in half cycles
	localparam int AWH_SETUP_HALF = 1;
	localparam int AWH_SETUP_CYC = (AWH_SETUP_HALF + 1) / 2;
	// hold time is code + 0.5 cycles; the half rounds up to one cycle
	localparam logic [4:0] AWH_HOLD_EXTRA = 5'h01;

	typedef enum logic [2:0] {
		AWH_IDLE,
		AWH_SETUP,
		AWH_STROBE,
		AWH_HOLD
	} awh_fsm_t;

	// software-visible configuration of the area
	typedef struct packed {
		logic [3:0] rd_wait;
		logic       ext_mask;
		logic [1:0] hold;
	} awh_cfg_t;

	// one access request from the internal side
	typedef struct packed {
		logic        we;
		logic [23:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} awh_req_t;

	// whole state of the controller
	typedef struct packed {
		awh_cfg_t    cfg;
		awh_fsm_t    fsm;
		logic [4:0]  cnt;
		logic [1:0]  acc_hold;
		logic [3:0]  acc_wait;
		awh_req_t    req;
		logic        cs_act;
		logic        strobe;
		logic        rsp_valid;
		logic [31:0] rdata;
		logic [31:0] prdata;
		logic        slverr;
	} awh_core_t;

	localparam awh_core_t AWH_CORE_RST = '{
		cfg:       '{rd_wait: AWH_RD_WAIT_RST, ext_mask: AWH_EXT_MASK_RST,
		             hold: AWH_HOLD_RST},
		fsm:       AWH_IDLE,
		cnt:       5'h00,
		acc_hold:  2'h0,
		acc_wait:  4'h0,
		req:       '{we: 1'b0, addr: 24'h000000, wdata: 32'h00000000,
		             be: 4'h0},
		cs_act:    1'b0,
		strobe:    1'b0,
		rsp_valid: 1'b0,
		rdata:     32'h00000000,
		prdata:    32'h00000000,
		slverr:    1'b0
	};

	// read wait code to cycles; prohibited codes fall back to the longest
	function automatic logic [4:0] awh_rd_wait_cycles(input logic [3:0] code);
		logic [4:0] cyc;
		cyc = 5'h18;
		case (code)
			4'h0: cyc = 5'h00;
			4'h1: cyc = 5'h01;
			4'h2: cyc = 5'h02;
			4'h3: cyc = 5'h03;
			4'h4: cyc = 5'h04;
			4'h5: cyc = 5'h05;
			4'h6: cyc = 5'h06;
			4'h7: cyc = 5'h08;
			4'h8: cyc = 5'h0a;
			4'h9: cyc = 5'h0c;
			4'ha: cyc = 5'h0e;
			4'hb: cyc = 5'h12;
			4'hc: cyc = 5'h18;
			default: cyc = 5'h18;
		endcase
		return cyc;
	endfunction : awh_rd_wait_cycles

endpackage : awh_pkg

/* File: sim/awh_mem_model.sv */
// Purpose: memory or peripheral on the far side of one select area
// Assumes: wait pin has a pull-up, so it idles high when not armed
// Notes:   unselected data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module awh_mem_model (
	input  wire logic        pclk,               // bus clock
	input  wire logic        area_select_n,      // area select, low
	input  wire logic        rd_n,               // read strobe, low
	input  wire logic [3:0]  byte_lane_strobe_n, // write strobes, low
	input  wire logic        ext_data_oe,        // controller drives data
	input  wire logic [23:0] ext_addr,           // address pins
	input  wire logic [7:0]  wait_len,           // strobe cycles in wait
	output logic      [31:0] ext_data_in,        // data toward controller
	output logic             ext_wait_n          // wait pin, low
);
	logic [7:0]  ws = 8'h00;
	logic [31:0] dq = 32'h00000000;
	logic        strobe;
	// armed wait is low even before the access, so the two-flop
	// delay cannot hide it from a zero-wait access
	assign strobe = !rd_n || (byte_lane_strobe_n != 4'hf);
	assign ext_wait_n = !(wait_len != 8'h00 && ws < wait_len);
	assign ext_data_in = dq;
	// count strobe cycles; data only valid while selected for a read
	always @(posedge pclk) begin
		ws <= strobe ? ws + 8'h01 : 8'h00;
		if (!area_select_n && !ext_data_oe)
			dq <= {ext_addr, 8'h5a};
		else
			dq <= ~dq;
	end
endmodule : awh_mem_model
`default_nettype wire

/* File: sim/tb_awh_ctrl.sv */
// Purpose: self-checking bench for the area wait/hold controller
// Assumes: apb slave answers with pready; one access at a time
// Notes:   strobe and hold lengths are counted at falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_awh_ctrl;
	import awh_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic req_valid, req_ready, rsp_valid, area_select_n, rd_n;
	logic ext_data_oe, ext_wait_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rsp_rdata, ext_data_out, ext_data_in;
	logic [3:0]  byte_lane_strobe_n, pstrb;
	logic [23:0] ext_addr;
	logic [7:0]  wait_len;
	logic [31:0] seed;
	awh_req_t    req;
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;

	awh_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .req_valid,
		.req, .req_ready, .rsp_valid, .rsp_rdata, .ext_addr,
		.area_select_n, .rd_n, .byte_lane_strobe_n, .ext_data_out,
		.ext_data_oe, .ext_data_in, .ext_wait_n);
	awh_mem_model mem (.pclk, .area_select_n, .rd_n, .byte_lane_strobe_n,
		.ext_data_oe, .ext_addr, .wait_len, .ext_data_in, .ext_wait_n);

	// clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// read wait code to cycles, worked out independently
	function automatic int wcyc(input logic [3:0] c);
		case (c)
			4'h7: return 8;
			4'h8: return 10;
			4'h9: return 12;
			4'ha: return 14;
			4'hb: return 18;
			4'hc: return 24;
			default: return int'(c);
		endcase
	endfunction : wcyc

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	// one apb transfer; held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one memory access; strobe and hold cycles counted till rsp_valid
	task automatic access(input logic we, output int sl, output int hl,
		output logic [31:0] rd, output logic [23:0] a);
		logic [31:0] r;
		logic [31:0] d;
		logic [3:0]  be;
		logic [3:0]  lanes;
		r = xs();
		d = xs();
		a = r[23:0];
		be = r[27:24] | 4'h1;
		lanes = we ? ~be : 4'hf;
		@(posedge pclk);
		req_valid <= 1'b1;
		req <= '{we: we, addr: a, wdata: d, be: be};
		@(posedge pclk);
		req_valid <= 1'b0;
		sl = 0;
		hl = 0;
		for (int n = 0; n < 400; n++) begin
			@(negedge pclk);
			if (rsp_valid === 1'b1) break;
			if (rd_n === 1'b0 || byte_lane_strobe_n !== 4'hf) begin
				sl++;
				chk({28'h0, byte_lane_strobe_n}, {28'h0, lanes});
				chk({31'h0, ext_data_oe}, {31'h0, we});
				if (we)
					chk(ext_data_out, d);
			end else if (area_select_n === 1'b0 && sl > 0) begin
				hl++;
				chk({8'h0, ext_addr}, {8'h0, a});
			end
		end
		// a run-out limit leaves rsp_valid low and counts as a mismatch
		chk({30'h0, rsp_valid, req_ready}, 32'h3);
		rd = rsp_rdata;
	endtask : access

	// main sequence: first half walks codes 0 to 12 with wait, rest random
	initial begin
		logic [31:0] r, cfg;
		logic [23:0] a;
		logic [3:0]  code;
		logic        e, mask, waitd, we;
		int          sl, hl, w;
		presetn = 1'b0;
		{psel, penable, pwrite, req_valid} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		req = '0;
		pstrb = 4'hf;
		wait_len = 8'h00;
		seed = 32'h0000000d;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0, r, e);
		chk(r, 32'h00000500);
		apb(1'b1, 12'h000, 32'h00000643, r, e);
		apb(1'b0, 12'h000, 32'h0, r, e);
		chk(r, 32'h00000643);
		// upper lane only: read wait bits 3:1 cleared, the rest kept
		pstrb <= 4'h2;
		apb(1'b1, 12'h000, 32'h00000000, r, e);
		pstrb <= 4'hf;
		apb(1'b0, 12'h000, 32'h0, r, e);
		chk(r, 32'h00000043);
		apb(1'b0, 12'h010, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h00000000);
		for (int i = 0; i < 52; i++) begin
			r = xs();
			code = (i < 26) ? 4'(i % 13) : 4'(r[31:8] % 13);
			mask = (i < 26) ? (i >= 13) : r[0];
			waitd = (i < 26) || r[3];
			we = r[4];
			cfg = {21'h0, code, mask, 4'h0, r[2:1]};
			apb(1'b1, 12'h000, cfg, r, e);
			apb(1'b0, 12'h000, 32'h0, r, e);
			chk(r, cfg);
			w = wcyc(code);
			wait_len <= waitd ? 8'(w + 6) : 8'h00;
			access(we, sl, hl, r, a);
			if (waitd && !mask)
				chk(32'(sl > w + 1), 32'h1);
			else
				chk(sl, w + 1);
			chk(hl, cfg[1:0] + 1);
			if (!we && code > 4'h3)
				chk(r, {a, 8'h5a});
		end
		tally_and_finish();
	end
endmodule : tb_awh_ctrl
`default_nettype wire

/* File: src/awh_ctrl.sv */
// Purpose: one chip-select area: read wait, external wait mask, strobe hold
// Assumes: apb slave with no wait states; pins sampled through two flops
// Notes:   external wait and read data arrive two cycles late via syncs
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - read strobe lasts 1 plus 0..6,8,10,12,14,18,24 wait cycles by code
// - read wait field resets to 1010, fourteen wait cycles
// - mask bit 0 honours external wait, 1 ignores it; resets to 0
// - the mask applies even when the wait count is zero
// - bits 5 to 2 read as zero; software writes zero there
// - address and select stay after strobe for hold code plus half
module awh_ctrl
	import awh_pkg::*;
(
	input  wire logic          pclk,               // bus clock
	input  wire logic          presetn,            // async reset, low
	input  wire logic          psel,               // apb select
	input  wire logic          penable,            // apb access phase
	input  wire logic          pwrite,             // apb direction
	input  wire logic [11:0]   paddr,              // apb byte address
	input  wire logic [31:0]   pwdata,             // apb write data
	input  wire logic [3:0]    pstrb,              // apb byte strobes
	output logic      [31:0]   prdata,             // apb read data
	output logic               pready,             // apb ready
	output logic               pslverr,            // apb error
	input  wire logic          req_valid,          // access request
	input  wire awh_pkg::awh_req_t req,            // request contents
	output logic               req_ready,          // request taken
	output logic               rsp_valid,          // access done pulse
	output logic      [31:0]   rsp_rdata,          // read data
	output logic      [23:0]   ext_addr,           // memory address
	output logic               area_select_n,      // area select, low
	output logic               rd_n,               // read strobe, low
	output logic      [3:0]    byte_lane_strobe_n, // write strobes, low
	output logic      [31:0]   ext_data_out,       // write data to pins
	output logic               ext_data_oe,        // data pins driven
	input  wire logic [31:0]   ext_data_in,        // data pins in
	input  wire logic          ext_wait_n          // external wait, low
);
	import awh_pkg::*;

	awh_core_t   st;
	awh_core_t   next_st;
	logic        wait_sync_n;
	logic [31:0] data_sync;
	logic        wait_act;
	logic        apb_setup;
	logic        apb_access;
	logic        hit;
	logic [31:0] reg_word;

	// pin inputs pass two flops before use
	awh_sync #(.WIDTH(1), .RST(1'b1)) u_wait_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (ext_wait_n),
		.q     (wait_sync_n)
	);

	awh_sync #(.WIDTH(32), .RST(32'h00000000)) u_data_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (ext_data_in),
		.q     (data_sync)
	);

	// decode of apb phases and register image
	always_comb begin
		apb_setup  = psel & ~penable;
		apb_access = psel & penable;
		hit        = (paddr == AWH_WAIT_CTRL_OFS);
		reg_word   = 32'h00000000; // reserved bits stay zero
		reg_word[AWH_RD_WAIT_MSB:AWH_RD_WAIT_LSB] = st.cfg.rd_wait;
		reg_word[AWH_EXT_MASK_BIT] = st.cfg.ext_mask;
		reg_word[AWH_HOLD_MSB:AWH_HOLD_LSB] = st.cfg.hold;
		// wait is looked at only when unmasked
		wait_act   = ~wait_sync_n & ~st.cfg.ext_mask;
	end

	// next state: register file and access sequencer
	always_comb begin
		next_st = st;
		next_st.rsp_valid = 1'b0;

		// read data and error are prepared in the setup phase
		if (apb_setup) begin
			next_st.slverr = ~hit;
			next_st.prdata = hit ? reg_word : 32'h00000000;
		end
		// writes land at the access edge; reserved bits are dropped
		if (apb_access && pwrite && hit) begin
			if (pstrb[0]) begin
				next_st.cfg.rd_wait[0] = pwdata[AWH_RD_WAIT_LSB];
				next_st.cfg.ext_mask   = pwdata[AWH_EXT_MASK_BIT];
				next_st.cfg.hold = pwdata[AWH_HOLD_MSB:AWH_HOLD_LSB];
			end
			if (pstrb[1]) begin
				next_st.cfg.rd_wait[3:1] =
					pwdata[AWH_RD_WAIT_MSB:AWH_RD_WAIT_LSB+1];
			end
		end

		case (st.fsm)
			AWH_IDLE: begin
				if (req_valid) begin
					// wait and hold codes are frozen per access, so a write mid-access
					// cannot change their counts; the mask bit is used live
					next_st.req      = req;
					next_st.acc_wait = st.cfg.rd_wait;
					next_st.acc_hold = st.cfg.hold;
					next_st.cs_act   = 1'b1;
					next_st.fsm      = AWH_SETUP;
				end
			end
			AWH_SETUP: begin
				// half-cycle setup rounds up to one cycle
				next_st.strobe = 1'b1;
				next_st.cnt    = awh_rd_wait_cycles(st.acc_wait);
				next_st.fsm    = AWH_STROBE;
			end
			AWH_STROBE: begin
				if (st.cnt != 5'h00) begin
					next_st.cnt = st.cnt - 5'h01;
				end else if (wait_act) begin
					// hold here while wait is asserted, even at zero count
					next_st.fsm = AWH_STROBE;
				end else begin
					next_st.strobe = 1'b0;
					next_st.rdata  = st.req.we ? 32'h00000000 : data_sync;
					next_st.cnt    = {3'h0, st.acc_hold};
					next_st.fsm    = AWH_HOLD;
				end
			end
			AWH_HOLD: begin
				// select and address held code+1 cycles past strobe
				if (st.cnt != 5'h00) begin
					next_st.cnt = st.cnt - AWH_HOLD_EXTRA;
				end else begin
					next_st.cs_act    = 1'b0;
					next_st.rsp_valid = 1'b1;
					next_st.fsm       = AWH_IDLE;
				end
			end
			default: begin
				next_st = AWH_CORE_RST;
			end
		endcase
	end

	// single state register; reset loads constants only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= AWH_CORE_RST;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from state, handshakes combinational
	assign prdata        = st.prdata;
	assign pslverr       = st.slverr & psel & penable;
	assign pready        = 1'b1;     // zero-wait slave keeps the bus simple
	assign req_ready     = (st.fsm == AWH_IDLE);
	assign rsp_valid     = st.rsp_valid;
	assign rsp_rdata     = st.rdata;
	assign ext_addr      = st.req.addr;
	assign area_select_n = ~st.cs_act;
	assign rd_n          = ~(st.strobe & ~st.req.we);
	assign byte_lane_strobe_n = ~({4{st.strobe & st.req.we}} & st.req.be);
	assign ext_data_out  = st.req.wdata;
	// data driven for the whole selected write, hold included
	assign ext_data_oe   = st.cs_act & st.req.we;

	// helper counters watched only by the checks below
	logic [5:0] strobe_len;
	logic [2:0] hold_len;
	logic       stretched;

	// count strobe and hold cycles of the current access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_len <= 6'h00;
			hold_len   <= 3'h0;
			stretched  <= 1'b0;
		end else begin
			strobe_len <= (st.fsm == AWH_STROBE) ? strobe_len + 6'h01 : 6'h00;
			hold_len   <= (st.fsm == AWH_HOLD) ? hold_len + 3'h1 : 3'h0;
			if (st.fsm == AWH_SETUP) begin
				stretched <= 1'b0;
			end else if (st.fsm == AWH_STROBE && st.cnt == 5'h00
				&& wait_act) begin
				stretched <= 1'b1;
			end
		end
	end

	sequence s_strobe_end;
		st.fsm == AWH_STROBE ##1 st.fsm == AWH_HOLD;
	endsequence

	sequence s_wait_seen;
		st.fsm == AWH_STROBE && st.cnt == 5'h00 && wait_act;
	endsequence

	// checks watch state, next state, wait_act, helper counters and ports only, never the bench
	// the reset check looks once, at the first edge after release
	a_wait_reset_value: assert property (
		@(posedge pclk) disable iff (!presetn)
		!$past(presetn) |-> st.cfg.rd_wait == AWH_RD_WAIT_RST
			&& st.cfg.ext_mask == AWH_EXT_MASK_RST
			&& st.cfg.hold == AWH_HOLD_RST
	) else $error("read wait or mask wrong after reset");

	// stretched accesses are left out: their length follows the pin
	a_strobe_length: assert property (
		@(posedge pclk) disable iff (!presetn)
		(st.fsm == AWH_STROBE && next_st.fsm == AWH_HOLD && !stretched)
		|-> strobe_len == {1'b0, awh_rd_wait_cycles(st.acc_wait)}
	) else $error("strobe length does not match read wait code");

	a_wait_stretches: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_wait_seen |=> st.fsm == AWH_STROBE && st.strobe
	) else $error("honoured external wait did not stretch access");

	// wait seen two cycles late must still hold a zero-wait access
	a_zero_wait_mask: assert property (
		@(posedge pclk) disable iff (!presetn)
		(st.fsm == AWH_SETUP && st.acc_wait == 4'h0 && wait_act)
		##1 wait_act |=> st.fsm == AWH_STROBE
	) else $error("zero wait access ignored unmasked wait");

	a_mask_ignores: assert property (
		@(posedge pclk) disable iff (!presetn)
		(st.fsm == AWH_STROBE && st.cnt == 5'h00 && st.cfg.ext_mask)
		|=> st.fsm == AWH_HOLD && !st.strobe
	) else $error("masked external wait still stretched access");

	a_reserved_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pwrite)
		|-> prdata[AWH_RSVD_MSB:AWH_RSVD_LSB] == 4'h0
	) else $error("reserved bits read nonzero");

	a_hold_select: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_strobe_end |-> !area_select_n && rd_n
			&& byte_lane_strobe_n == 4'hf
	) else $error("select dropped together with strobe");

	a_hold_length: assert property (
		@(posedge pclk) disable iff (!presetn)
		(st.fsm == AWH_HOLD && !st.cs_act == 1'b0 && next_st.fsm == AWH_IDLE)
		|-> hold_len == {1'b0, st.acc_hold} ##1 area_select_n
	) else $error("hold time does not match hold code");

	// release of the synchronised wait ends the stretch at the next edge
	sequence s_wait_clear;
		st.fsm == AWH_STROBE && st.cnt == 5'h00 && !wait_act;
	endsequence

	// a stuck stretch would hang the requester, so bound the release
	a_wait_release: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_wait_clear |=> st.fsm == AWH_HOLD && !st.strobe
	) else $error("access not ended after external wait released");

	// select leads the strobe by the rounded-up setup cycle
	a_setup_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		st.fsm == AWH_SETUP |-> !area_select_n && rd_n
			&& byte_lane_strobe_n == 4'hf
	) else $error("strobe active during setup cycle");

	// read and write strobes never overlap
	a_strobe_excl: assert property (
		@(posedge pclk) disable iff (!presetn)
		!rd_n |-> byte_lane_strobe_n == 4'hf
	) else $error("read and write strobes active together");

	// address and write data must not move before select is released
	a_hold_addr: assert property (
		@(posedge pclk) disable iff (!presetn)
		st.fsm == AWH_HOLD
		|=> $stable(ext_addr) && $stable(ext_data_out)
	) else $error("address changed during hold time");

	// a mask bit write lands at the access edge of the transfer
	a_mask_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && pstrb[0]
			&& paddr == AWH_WAIT_CTRL_OFS)
		|=> st.cfg.ext_mask == $past(pwdata[AWH_EXT_MASK_BIT])
	) else $error("mask bit write did not land");

	// unmapped words read as zero and are refused
	a_unmapped_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && paddr != AWH_WAIT_CTRL_OFS)
		|-> pslverr && prdata == 32'h00000000
	) else $error("unmapped access not refused");

endmodule : awh_ctrl
`default_nettype wire

/* File: src/awh_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: d is asynchronous to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module awh_sync #(
	parameter int              WIDTH = 1,
	parameter logic [WIDTH-1:0] RST  = '0
) (
	input  wire logic             clk,     // sampling clock
	input  wire logic             rst_n,   // async reset, active low
	input  wire logic [WIDTH-1:0] d,       // asynchronous input
	output logic      [WIDTH-1:0] q        // synchronised output
);
	logic [WIDTH-1:0] meta;

	// two stages to let metastability settle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= RST;
			q    <= RST;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : awh_sync
`default_nettype wire
